// file: rtl/mcr_cfg.svh
// Register indices, field positions, reset values and divider figures
`ifndef MCR_CFG_SVH
`define MCR_CFG_SVH
`define MCR_ADDR_W 8
`define MCR_IDX_CTRL 6'h2c
`define MCR_IDX_BEEP 6'h2d
`define MCR_IDX_ISTAT 6'h2e
`define MCR_IDX_IMASK 6'h2f
`define MCR_CTRL_RST 8'h00
`define MCR_BEEP_RST 2'h0
`define MCR_IRQ_RST 2'h0
`define MCR_IRQ_B_TICK 0
`define MCR_IRQ_B_WAKE 1
`define MCR_RESP_OKAY 2'h0
`define MCR_RESP_SLVERR 2'h2
`define MCR_TB_DIV0 16000
`define MCR_TB_DIV1 32000
`define MCR_TB_DIV2 80000
`define MCR_TB_DIV3 200000
`define MCR_BEEP_REF_HZ 8000000
`define MCR_BEEP_HZ1 2000
`define MCR_BEEP_HZ2 1000
`define MCR_BEEP_HZ3 500
`endif

// file: rtl/mcr_pkg.sv
// Types shared by the clock and tick unit
package mcr_pkg;
  typedef enum logic [1:0] {MCR_RUN, MCR_TIMED_HALT, MCR_FULL_HALT} mcr_mode_t;
  typedef enum logic [2:0] {MCR_SEL_CTRL, MCR_SEL_BEEP, MCR_SEL_ISTAT, MCR_SEL_IMASK,
    MCR_SEL_NONE} mcr_sel_t;
  // Field order matches the control/status byte, bit 7 first
  typedef struct packed {
    logic clock_out_enable;
    logic [1:0] slow_divider_select;
    logic slow_mode_select;
    logic [1:0] time_base_select;
    logic tick_irq_enable;
    logic tick_irq_flag;
  } mcr_ctrl_t;
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } mcr_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mcr_axi_rsp_t;
  typedef struct packed {
    logic clk_out;
    logic clk_out_oe_n;
    logic beep_out;
    logic beep_oe_n;
  } mcr_pins_t;
endpackage : mcr_pkg

// file: rtl/mcr_top.sv
// Main clock controller with tick timer, clock-out and beeper behind AXI4-Lite
// What this block does
// - slow mode divides by 2, 4, 8, 16
// - normal mode passes oscillator clock to CPU
// - clock-out enable drives clock on pin
// - clock-out pin stops during timed halt
// - tick period 16000/32000/80000/200000 oscillator cycles
// - new time base applies after current period
// - period end sets flag; register read in run mode clears
// - interrupt needs enable and global mask clear
// - halt with enable enters timed halt
// - wait mode unaffected; tick wakes from wait
// - timed halt keeps counting; tick ends it
// - full halt freezes; tick cannot wake
// - control/status register resets to zero
// - tick and beep run apart from prescaler; clock-out follows prescaler
// - beep register drives beep pin tones
// - beep codes off, 2k, 1k, 500 Hz
`timescale 1ns/100ps
`include "mcr_cfg.svh"
module mcr_top import mcr_pkg::*; #(
  parameter int TB_DIV0 = `MCR_TB_DIV0,
  parameter int TB_DIV1 = `MCR_TB_DIV1,
  parameter int TB_DIV2 = `MCR_TB_DIV2,
  parameter int TB_DIV3 = `MCR_TB_DIV3,
  parameter int BEEP_HALF1 = `MCR_BEEP_REF_HZ / (2 * `MCR_BEEP_HZ1),
  parameter int BEEP_HALF2 = `MCR_BEEP_REF_HZ / (2 * `MCR_BEEP_HZ2),
  parameter int BEEP_HALF3 = `MCR_BEEP_REF_HZ / (2 * `MCR_BEEP_HZ3)
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire mcr_axi_req_t axi_req,
  output mcr_axi_rsp_t axi_rsp,
  // CPU power state
  input wire logic wait_mode,
  input wire logic halt_instr,
  input wire logic global_irq_mask,
  input wire logic ext_wake,
  // Clock and mode outputs
  output logic cpu_clk_en,
  output logic timed_halt,
  output logic full_halt,
  output logic wake_from_wait,
  // Interrupts
  output logic tick_irq_req,
  output logic irq,
  // Port pins
  output mcr_pins_t pins
);

  typedef struct packed {
    mcr_ctrl_t ctrl;
    logic [1:0] beep_freq_select;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    mcr_mode_t mode;
    logic [1:0] tb_active;
    logic [17:0] tb_cnt;
    logic [3:0] pre_cnt;
    logic clk_out_q;
    logic [12:0] beep_cnt;
    logic beep_q;
    logic aw_have;
    logic [5:0] aw_idx;
    logic w_have;
    logic [7:0] wdata;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } mcr_state_t;

  localparam mcr_state_t RESET_STATE = '{
    ctrl: `MCR_CTRL_RST, beep_freq_select: `MCR_BEEP_RST, irq_status: `MCR_IRQ_RST,
    irq_mask: `MCR_IRQ_RST, mode: MCR_RUN, default: '0};

  mcr_state_t s;
  mcr_state_t next_s;

  function automatic mcr_sel_t decode(input logic [5:0] idx);
    unique case (idx)
      `MCR_IDX_CTRL: decode = MCR_SEL_CTRL;
      `MCR_IDX_BEEP: decode = MCR_SEL_BEEP;
      `MCR_IDX_ISTAT: decode = MCR_SEL_ISTAT;
      `MCR_IDX_IMASK: decode = MCR_SEL_IMASK;
      default: decode = MCR_SEL_NONE;
    endcase
  endfunction : decode

  function automatic logic [17:0] tb_last(input logic [1:0] sel);
    unique case (sel)
      2'h0: tb_last = 18'(TB_DIV0 - 1);
      2'h1: tb_last = 18'(TB_DIV1 - 1);
      2'h2: tb_last = 18'(TB_DIV2 - 1);
      2'h3: tb_last = 18'(TB_DIV3 - 1);
    endcase
  endfunction : tb_last

  function automatic logic [12:0] beep_last(input logic [1:0] sel);
    unique case (sel)
      2'h1: beep_last = 13'(BEEP_HALF1 - 1);
      2'h2: beep_last = 13'(BEEP_HALF2 - 1);
      2'h3: beep_last = 13'(BEEP_HALF3 - 1);
      default: beep_last = 13'h0;
    endcase
  endfunction : beep_last

  logic running;
  logic osc_on;
  logic tb_done;
  logic [3:0] div_mask;
  logic do_write;
  logic do_read;
  mcr_sel_t wsel;
  mcr_sel_t rsel;
  logic rd_clear;
  logic tick_wake;
  logic [1:0] irq_events;
  logic slow_four;

  assign running = (s.mode == MCR_RUN);
  // Oscillator stops only in full halt
  assign osc_on = (s.mode != MCR_FULL_HALT);
  assign tb_done = osc_on && (s.tb_cnt == tb_last(s.tb_active));
  // ratio mask from slow divider field
  assign div_mask = {s.ctrl.slow_divider_select == 2'h3, s.ctrl.slow_divider_select >= 2'h2,
    s.ctrl.slow_divider_select != 2'h0, 1'b1};
  assign cpu_clk_en = running && (!s.ctrl.slow_mode_select ||
    ((s.pre_cnt & div_mask) == div_mask));
  assign do_write = s.aw_have && s.w_have && !s.bvalid;
  assign do_read = axi_req.arvalid && !s.rvalid;
  assign wsel = decode(s.aw_idx);
  assign rsel = decode(axi_req.araddr[7:2]);
  // reading the control register while running clears the flag
  assign rd_clear = do_read && running && (rsel == MCR_SEL_CTRL);
  assign tick_wake = tb_done && s.ctrl.tick_irq_enable;
  assign irq_events = {(s.mode == MCR_TIMED_HALT) && (tick_wake || ext_wake), tb_done};
  // The divide by 4 setting is in force and the core is running
  assign slow_four = running && s.ctrl.slow_mode_select && (s.ctrl.slow_divider_select == 2'h1);

  always_comb begin
    next_s = s;
    // Prescaler counts in run mode only and is not cleared on a ratio change, so switching ratio needs no resync
    next_s.pre_cnt = running ? s.pre_cnt + 4'h1 : s.pre_cnt;
    // tick counter and beep pin advance apart from the prescaler; clock-out follows it
    if (osc_on) begin
      if (tb_done) begin
        next_s.tb_cnt = 18'h0;
        // latch new time base only at period end
        next_s.tb_active = s.ctrl.time_base_select;
      end else begin
        next_s.tb_cnt = s.tb_cnt + 18'h1;
      end
    end
    // clock-out follows the CPU clock enable
    if (!s.ctrl.clock_out_enable) begin
      next_s.clk_out_q = 1'b0;
    end else if (cpu_clk_en) begin
      // no enables outside run, so the pin holds in halt
      next_s.clk_out_q = !s.clk_out_q;
    end
    if (s.beep_freq_select == 2'h0) begin
      next_s.beep_cnt = 13'h0;
      next_s.beep_q = 1'b0;
    end else if (osc_on) begin
      if (s.beep_cnt >= beep_last(s.beep_freq_select)) begin
        next_s.beep_cnt = 13'h0;
        next_s.beep_q = !s.beep_q;
      end else begin
        next_s.beep_cnt = s.beep_cnt + 13'h1;
      end
    end
    // set wins over the read clear
    next_s.ctrl.tick_irq_flag = tb_done || (s.ctrl.tick_irq_flag && !rd_clear);
    next_s.irq_status = s.irq_status | irq_events;
    // Write address and data are taken in either order
    if (axi_req.awvalid && !s.aw_have && !s.bvalid) begin
      next_s.aw_have = 1'b1;
      next_s.aw_idx = axi_req.awaddr[7:2];
    end
    if (axi_req.wvalid && !s.w_have && !s.bvalid) begin
      next_s.w_have = 1'b1;
      next_s.wdata = axi_req.wdata[7:0];
      next_s.w_lane = axi_req.wstrb[0];
    end
    if (do_write) begin
      next_s.aw_have = 1'b0;
      next_s.w_have = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = (wsel == MCR_SEL_NONE) ? `MCR_RESP_SLVERR : `MCR_RESP_OKAY;
      if (s.w_lane && running) begin
        unique case (wsel)
          MCR_SEL_CTRL: begin
            // Flag bit is read-only to software
            next_s.ctrl = {s.wdata[7:1], next_s.ctrl.tick_irq_flag};
          end
          // beep register steers the beep pin
          MCR_SEL_BEEP: next_s.beep_freq_select = s.wdata[1:0];
          MCR_SEL_ISTAT: next_s.irq_status = irq_events | (s.irq_status & ~s.wdata[1:0]);
          MCR_SEL_IMASK: next_s.irq_mask = s.wdata[1:0];
          MCR_SEL_NONE: next_s.bresp = `MCR_RESP_SLVERR;
        endcase
      end
    end else if (s.bvalid && axi_req.bready) begin
      next_s.bvalid = 1'b0;
    end
    if (do_read) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = (rsel == MCR_SEL_NONE) ? `MCR_RESP_SLVERR : `MCR_RESP_OKAY;
      unique case (rsel)
        MCR_SEL_CTRL: next_s.rdata = s.ctrl;
        MCR_SEL_BEEP: next_s.rdata = {6'h00, s.beep_freq_select};
        MCR_SEL_ISTAT: next_s.rdata = {6'h00, s.irq_status};
        MCR_SEL_IMASK: next_s.rdata = {6'h00, s.irq_mask};
        MCR_SEL_NONE: next_s.rdata = 8'h00;
      endcase
    end else if (s.rvalid && axi_req.rready) begin
      next_s.rvalid = 1'b0;
    end
    unique case (s.mode)
      MCR_RUN: begin
        if (halt_instr) begin
          // enable selects timed halt over full halt
          next_s.mode = s.ctrl.tick_irq_enable ? MCR_TIMED_HALT : MCR_FULL_HALT;
        end
      end
      MCR_TIMED_HALT: begin
        if (tick_wake || ext_wake) begin
          next_s.mode = MCR_RUN;
        end
      end
      MCR_FULL_HALT: begin
        // only an external wake leaves full halt
        if (ext_wake) begin
          next_s.mode = MCR_RUN;
        end
      end
      default: next_s.mode = MCR_RUN;
    endcase
  end

  always_ff @(posedge aclk) begin
    // all control bits clear at reset
    if (!aresetn) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  // request needs enable and open global mask
  assign tick_irq_req = s.ctrl.tick_irq_flag && s.ctrl.tick_irq_enable && !global_irq_mask;
  assign wake_from_wait = wait_mode && tick_irq_req;
  assign irq = |(s.irq_status & s.irq_mask);
  assign timed_halt = (s.mode == MCR_TIMED_HALT);
  assign full_halt = (s.mode == MCR_FULL_HALT);
  assign pins = '{clk_out: s.clk_out_q, clk_out_oe_n: !s.ctrl.clock_out_enable,
    beep_out: s.beep_q, beep_oe_n: (s.beep_freq_select == 2'h0)};
  assign axi_rsp = '{awready: !s.aw_have && !s.bvalid, wready: !s.w_have && !s.bvalid,
    bvalid: s.bvalid, bresp: s.bresp, arready: !s.rvalid, rvalid: s.rvalid,
    rdata: {24'h000000, s.rdata}, rresp: s.rresp};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A ratio change or a halt inside the window suspends the spacing check
  slow_div_four_a: assert property (
    cpu_clk_en && slow_four |=> (!cpu_clk_en || !slow_four) [*3] ##1
    (cpu_clk_en || !slow_four))
    else $error("slow divide by 4 spacing wrong");
  normal_rate_a: assert property (
    running && !s.ctrl.slow_mode_select |-> cpu_clk_en)
    else $error("normal mode lost a CPU clock enable");
  clk_out_idle_a: assert property (
    !s.ctrl.clock_out_enable |-> pins.clk_out_oe_n && !pins.clk_out)
    else $error("clock-out pin driven while disabled");
  halt_clk_out_a: assert property (
    s.mode == MCR_TIMED_HALT |=> $stable(pins.clk_out))
    else $error("clock-out toggled in timed halt");
  tb_count_range_a: assert property (
    s.tb_cnt <= tb_last(s.tb_active))
    else $error("tick counter past its period");
  tb_switch_a: assert property (
    !tb_done |=> $stable(s.tb_active))
    else $error("time base changed mid period");
  flag_set_a: assert property (
    tb_done |=> s.ctrl.tick_irq_flag)
    else $error("tick event did not set flag");
  flag_clear_a: assert property (
    rd_clear && !tb_done |=> !s.ctrl.tick_irq_flag)
    else $error("register read did not clear flag");
  irq_req_a: assert property (
    tick_irq_req |-> s.ctrl.tick_irq_enable && !global_irq_mask)
    else $error("tick request without enable");
  timed_entry_a: assert property (
    running && halt_instr && s.ctrl.tick_irq_enable |=> s.mode == MCR_TIMED_HALT)
    else $error("halt did not enter timed halt");
  full_freeze_a: assert property (
    s.mode == MCR_FULL_HALT && !ext_wake |=> $stable(s.tb_cnt) && $stable(s.ctrl) &&
    s.mode == MCR_FULL_HALT)
    else $error("full halt not frozen");
  timed_exit_a: assert property (
    s.mode == MCR_TIMED_HALT && tick_wake |=> running)
    else $error("tick did not end timed halt");
  // Tone off parks the beep pin low
  beep_idle_a: assert property (
    s.beep_freq_select == 2'h0 |=> !pins.beep_out)
    else $error("beep pin moved while tone off");
  // Every period end lands in the status register
  tick_status_a: assert property (
    tb_done |=> s.irq_status[`MCR_IRQ_B_TICK])
    else $error("tick event missing from status");
  timed_wake_bit_a: assert property (
    s.mode == MCR_TIMED_HALT && tick_wake |=> s.irq_status[`MCR_IRQ_B_WAKE])
    else $error("timed halt wake not recorded");
  full_entry_a: assert property (
    running && halt_instr && !s.ctrl.tick_irq_enable |=> s.mode == MCR_FULL_HALT)
    else $error("halt did not enter full halt");
  // Bus writes are dropped while halted, so settings hold
  halt_regs_hold_a: assert property (
    !running |=> $stable(s.ctrl[7:1]) && $stable(s.beep_freq_select) &&
    $stable(s.irq_mask))
    else $error("register changed while halted");

  tick_event_c: cover property (tb_done && s.ctrl.tick_irq_enable);
  timed_wake_c: cover property (s.mode == MCR_TIMED_HALT ##1 running);
  slow_clk_c: cover property (s.ctrl.slow_mode_select && s.ctrl.slow_divider_select == 2'h3
    && cpu_clk_en);
  beep_on_c: cover property (!pins.beep_oe_n && $rose(pins.beep_out));
  full_wake_c: cover property (full_halt ##1 running);

endmodule : mcr_top

// file: bench/mcr_cpu_model.sv
// CPU-side model that counts clock enables and pin edges
`timescale 1ns/100ps
module mcr_cpu_model (
  // Clock and count clear
  input wire logic aclk,
  input wire logic clr,
  // Observed clocks
  input wire logic cpu_clk_en,
  input wire logic clk_out,
  input wire logic beep_out,
  // Counts since last clear
  output int en_cnt,
  output int co_cnt,
  output int bp_cnt
);
  logic co_q;
  logic bp_q;
  always @(posedge aclk) begin
    co_q <= clk_out;
    bp_q <= beep_out;
    if (clr) begin
      en_cnt <= 0;
      co_cnt <= 0;
      bp_cnt <= 0;
    end else begin
      en_cnt <= en_cnt + int'(cpu_clk_en);
      co_cnt <= co_cnt + int'(clk_out != co_q);
      bp_cnt <= bp_cnt + int'(beep_out != bp_q);
    end
  end
endmodule : mcr_cpu_model

// file: bench/tb.sv
// Self-checking bench for the clock and tick unit
`timescale 1ns/100ps
`include "mcr_cfg.svh"
module tb;
  import mcr_pkg::*;
  localparam logic [7:0] A_CTRL = {`MCR_IDX_CTRL, 2'h0};
  localparam logic [7:0] A_BEEP = {`MCR_IDX_BEEP, 2'h0};
  localparam logic [7:0] A_IST = {`MCR_IDX_ISTAT, 2'h0};
  localparam logic [7:0] A_IMSK = {`MCR_IDX_IMASK, 2'h0};
  localparam int DIV [4] = '{16, 32, 80, 200};
  logic aclk, aresetn, wait_mode, halt_instr, global_irq_mask, ext_wake, clr, req_q;
  logic cpu_clk_en, timed_halt, full_halt, wake_from_wait, tick_irq_req, irq;
  mcr_axi_req_t req;
  mcr_axi_rsp_t rsp;
  mcr_pins_t pins;
  int en_cnt, co_cnt, bp_cnt, miscompares, checks, cyc, rises, rise_t;
  logic [31:0] d;
  logic [1:0] r;
  mcr_top #(.TB_DIV0(DIV[0]), .TB_DIV1(DIV[1]), .TB_DIV2(DIV[2]), .TB_DIV3(DIV[3]),
    .BEEP_HALF1(2), .BEEP_HALF2(4), .BEEP_HALF3(8)) u_mcr_top (.aclk(aclk),
    .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .wait_mode(wait_mode),
    .halt_instr(halt_instr), .global_irq_mask(global_irq_mask), .ext_wake(ext_wake),
    .cpu_clk_en(cpu_clk_en), .timed_halt(timed_halt), .full_halt(full_halt),
    .wake_from_wait(wake_from_wait), .tick_irq_req(tick_irq_req), .irq(irq), .pins(pins));
  mcr_cpu_model u_mcr_cpu_model (.aclk(aclk), .clr(clr), .cpu_clk_en(cpu_clk_en),
    .clk_out(pins.clk_out), .beep_out(pins.beep_out), .en_cnt(en_cnt), .co_cnt(co_cnt),
    .bp_cnt(bp_cnt));
  always #2 aclk = ~aclk;
  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // Rise times of the tick request, the reference for period figures
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    req_q <= tick_irq_req;
    if (tick_irq_req === 1'b1 && !req_q) begin
      rises <= rises + 1;
      rise_t <= cyc;
    end
    if (cyc == 10000) begin
      miscompares = miscompares + 1;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Ready flags are held high throughout, so each response is taken at once
  task automatic wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= dv;
    do begin
      @(posedge aclk);
      if (rsp.awready === 1'b1) aw = 1'b1;
      if (rsp.wready === 1'b1) w = 1'b1;
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
    end while (!(aw && w));
    do @(posedge aclk); while (rsp.bvalid !== 1'b1);
    rs = rsp.bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do @(posedge aclk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge aclk); while (rsp.rvalid !== 1'b1);
    dv = rsp.rdata;
    rs = rsp.rresp;
  endtask : rd
  // Wait for the next tick request, then clear the flag by a read
  task automatic wtick(output int t);
    int c;
    // A flag left pending keeps the request high and hides the next rise
    while (tick_irq_req === 1'b1) rd(A_CTRL, d, r);
    c = rises;
    while (rises == c) @(posedge aclk);
    t = rise_t;
    rd(A_CTRL, d, r);
  endtask : wtick
  task automatic hlt;
    @(posedge aclk);
    halt_instr <= 1'b1;
    @(posedge aclk);
    halt_instr <= 1'b0;
    @(negedge aclk);
  endtask : hlt
  task automatic t_regs;
    rd(A_CTRL, d, r);
    chk("ctrl", d, 0);
    chk("oe_n", {pins.clk_out_oe_n, pins.beep_oe_n}, 2'h3);
    wr(A_BEEP, 32'hffffffff, r);
    rd(A_BEEP, d, r);
    chk("beep", d, 3);
    req.wstrb <= 4'he;
    wr(A_BEEP, 0, r);
    rd(A_BEEP, d, r);
    chk("no lane", d, 3);
    req.wstrb <= 4'hf;
    rd(8'h00, d, r);
    chk("unmapped", {d[29:0], r}, `MCR_RESP_SLVERR);
    wr(8'h00, 1, r);
    chk("unmapped wr", r, `MCR_RESP_SLVERR);
  endtask : t_regs
  task automatic t_clk;
    for (int i = 0; i < 5; i++) begin
      wr(A_CTRL, (i == 0) ? 32'h80 : 32'h90 | ((i - 1) << 5), r);
      wr(A_BEEP, i % 4, r);
      repeat (16) @(posedge aclk);
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      repeat (64) @(posedge aclk);
      @(negedge aclk);
      chk("cpu clk", en_cnt, 64 >> i);
      chk("clk out", co_cnt, 64 >> i);
      chk("tone", bp_cnt, (i % 4 == 0) ? 0 : 64 >> (i % 4));
      chk("beep oe", pins.beep_oe_n, i % 4 == 0);
    end
    wr(A_CTRL, 0, r);
    @(negedge aclk);
    chk("co off", {pins.clk_out_oe_n, pins.clk_out}, 2'h2);
  endtask : t_clk
  task automatic t_tick;
    int a;
    int b;
    for (int i = 0; i < 4; i++) begin
      wr(A_CTRL, (i << 2) | 2, r);
      wtick(a);
      wtick(a);
      wtick(b);
      chk("period", b - a, DIV[i]);
    end
    wr(A_CTRL, 32'h06, r);
    wtick(a);
    chk("old base", a - b, DIV[3]);
    wtick(b);
    chk("new base", b - a, DIV[1]);
  endtask : t_tick
  task automatic t_irq;
    wr(A_CTRL, 32'h02, r);
    @(posedge aclk);
    global_irq_mask <= 1'b1;
    wr(A_IMSK, 1, r);
    wr(A_IST, 3, r);
    while (irq !== 1'b1) @(posedge aclk);
    @(negedge aclk);
    chk("masked req", tick_irq_req, 0);
    @(posedge aclk);
    global_irq_mask <= 1'b0;
    wait_mode <= 1'b1;
    @(negedge aclk);
    chk("req", tick_irq_req, 1);
    chk("wake wait", wake_from_wait, 1);
    @(posedge aclk);
    wait_mode <= 1'b0;
    rd(A_CTRL, d, r);
    chk("flag set", d[0], 1);
    rd(A_CTRL, d, r);
    chk("flag clr", d[0], 0);
    wr(A_IMSK, 0, r);
    repeat (20) @(posedge aclk);
    @(negedge aclk);
    chk("irq masked", irq, 0);
    rd(A_IST, d, r);
    chk("istat", d[0], 1);
  endtask : t_irq
  task automatic t_halt;
    int a;
    wr(A_CTRL, 32'h82, r);
    // Enter just after a tick so the stopped window fits in one period
    wtick(a);
    hlt();
    chk("timed", timed_halt, 1);
    @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk("co held", co_cnt + en_cnt, 0);
    repeat (16) @(posedge aclk);
    @(negedge aclk);
    chk("tick exit", timed_halt, 0);
    rd(A_IST, d, r);
    chk("wake bit", d[1], 1);
    wr(A_IST, 2, r);
    rd(A_IST, d, r);
    chk("w1c", d[1], 0);
    wr(A_CTRL, 32'h80, r);
    hlt();
    chk("full", full_halt, 1);
    wr(A_CTRL, 32'h02, r);
    repeat (300) @(posedge aclk);
    @(negedge aclk);
    chk("no tick wake", full_halt, 0 + 1);
    @(posedge aclk);
    ext_wake <= 1'b1;
    @(posedge aclk);
    ext_wake <= 1'b0;
    @(negedge aclk);
    chk("ext wake", full_halt, 0);
    rd(A_CTRL, d, r);
    chk("frozen", d[7:1], 7'h40);
  endtask : t_halt
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {wait_mode, halt_instr, global_irq_mask, ext_wake, clr, req_q} = 6'h0;
    {miscompares, checks, cyc, rises, rise_t} = '0;
    req = {1'b0, 8'h0, 1'b0, 32'h0, 4'hf, 1'b1, 1'b0, 8'h0, 1'b1};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_clk();
    t_tick();
    t_irq();
    t_halt();
    conclude();
  end
endmodule : tb
